/* File: core/usp_pkg.sv */
package usp_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int unsigned    USP_CNT_W        = 24;
	localparam int unsigned    USP_VA_W         = 48;
	localparam int unsigned    USP_PA_W         = 44;
	localparam int unsigned    USP_EV_W         = 32;
	localparam int unsigned    USP_EV_USED      = 13;
	localparam int unsigned    USP_SRC_W        = 8;
	localparam logic [23:0]    USP_CNT_RESET    = 24'h000400;
	localparam logic [23:0]    USP_MIN_INTERVAL = 24'h000400;
	localparam logic [47:0]    USP_REC_BYTES    = 48'h000000000040;

	// ----------------------------------------------------------------
	// Event field bit positions
	// ----------------------------------------------------------------
	localparam int unsigned    USP_EV_EXCEPTION = 0;
	localparam int unsigned    USP_EV_RETIRED   = 1;
	localparam int unsigned    USP_EV_L1D_ACC   = 2;
	localparam int unsigned    USP_EV_L1D_REF   = 3;
	localparam int unsigned    USP_EV_TLB_ACC   = 4;
	localparam int unsigned    USP_EV_DTLB_WALK = 5;
	localparam int unsigned    USP_EV_NOT_TAKEN = 6;
	localparam int unsigned    USP_EV_MISPRED   = 7;
	localparam int unsigned    USP_EV_LLC_ACC   = 8;
	localparam int unsigned    USP_EV_LLC_MISS  = 9;
	localparam int unsigned    USP_EV_REMOTE    = 10;
	localparam int unsigned    USP_EV_ALIGN     = 11;
	localparam int unsigned    USP_EV_LATE_PF   = 12;

	// ----------------------------------------------------------------
	// Data source codes
	// ----------------------------------------------------------------
	localparam logic [7:0]     USP_SRC_L1D      = 8'h00;
	localparam logic [7:0]     USP_SRC_L2       = 8'h08;
	localparam logic [7:0]     USP_SRC_PEER_CPU = 8'h09;
	localparam logic [7:0]     USP_SRC_LOCAL_CL = 8'h0a;
	localparam logic [7:0]     USP_SRC_SYS_CACHE = 8'h0b;
	localparam logic [7:0]     USP_SRC_PEER_CL  = 8'h0c;
	localparam logic [7:0]     USP_SRC_REMOTE   = 8'h0d;
	localparam logic [7:0]     USP_SRC_DRAM     = 8'h0e;

	// ----------------------------------------------------------------
	// Completion kinds and profiler states
	// ----------------------------------------------------------------
	localparam logic [1:0]     USP_DONE_RETIRE  = 2'h0;
	localparam logic [1:0]     USP_DONE_ABORT   = 2'h1;
	localparam logic [1:0]     USP_DONE_FLUSH   = 2'h2;

	typedef enum logic [2:0] {
		USP_IDLE      = 3'h0,
		USP_TRACK     = 3'h1,
		USP_XLAT_REQ  = 3'h2,
		USP_XLAT_WAIT = 3'h3,
		USP_PUSH      = 3'h4
	} usp_state_t;

	function automatic logic usp_src_legal(input logic [7:0] code);
		logic ok;
		ok = 1'b0;
		unique case (code)
			USP_SRC_L1D, USP_SRC_L2, USP_SRC_PEER_CPU, USP_SRC_LOCAL_CL,
			USP_SRC_SYS_CACHE, USP_SRC_PEER_CL, USP_SRC_REMOTE, USP_SRC_DRAM: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : usp_src_legal

endpackage : usp_pkg

/* File: core/usp_buf.sv */
`timescale 1ns/1ps
module usp_buf import usp_pkg::*; #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} usp_buf_st_t;

	usp_buf_st_t s_q;
	usp_buf_st_t s_d;
	logic        push;
	logic        pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : usp_buf

/* File: core/usp_profiler.sv */
`timescale 1ns/1ps
// Operation
// - Counter decrements once per dispatched micro-op.
// - Counter zero selects dispatching micro-op as sample; here only in USP_IDLE, otherwise the counter just reloads.
// - Samples are micro-ops, not whole instructions.
// - Tag sample; collect characteristics in internal registers.
// - Record written only after retire, abort, flush.
// - Minimum interval reported in identification field.
// - Record virtual address translated before memory write.
// - 32-bit event field, bits 31:13 reserved.
// - Bit 2 L1D access, bit 3 refill.
// - Bit 8 LLC access, bit 9 miss.
// - Load/store records carry 8-bit data source.
// - Only listed data-source codes are ever produced.
// - Never stall dispatch; only record path waits.
// - Disabled or top level: no samples, counter frozen.
module usp_profiler import usp_pkg::*; #(
	parameter int unsigned ID_W  = 8,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  prof_enable,
	input  wire logic                  el_top,
	input  wire logic [USP_CNT_W-1:0]  interval,
	input  wire logic [USP_VA_W-1:0]   base_va,
	output logic [USP_CNT_W-1:0]       profiling_id_register,
	input  wire logic                  disp_valid,
	input  wire logic [ID_W-1:0]       disp_uop_id,
	input  wire logic                  disp_is_ldst,
	output logic                       sample_tag,
	output logic                       tag_active,
	output logic [ID_W-1:0]            tag_uop_id,
	input  wire logic                  evt_valid,
	input  wire logic [ID_W-1:0]       evt_uop_id,
	input  wire logic [USP_EV_USED-1:0] evt_bits,
	input  wire logic                  src_valid,
	input  wire logic [ID_W-1:0]       src_uop_id,
	input  wire logic [USP_SRC_W-1:0]  src_code,
	input  wire logic                  done_valid,
	input  wire logic [ID_W-1:0]       done_uop_id,
	input  wire logic [1:0]            done_kind,
	output logic                       xlat_req_valid,
	input  wire logic                  xlat_req_ready,
	output logic [USP_VA_W-1:0]        xlat_va,
	input  wire logic                  xlat_rsp_valid,
	input  wire logic [USP_PA_W-1:0]   xlat_pa,
	input  wire logic                  xlat_fault,
	output logic                       fault,
	output logic                       mem_valid,
	input  wire logic                  mem_ready,
	output logic [USP_PA_W-1:0]        mem_pa,
	output logic [USP_EV_W-1:0]        mem_events,
	output logic [USP_SRC_W-1:0]       mem_source,
	output logic                       mem_ldst
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam int unsigned REC_W = USP_PA_W + USP_EV_W + USP_SRC_W + 1;

	typedef struct packed {
		usp_state_t             st;
		logic [USP_CNT_W-1:0]   cnt;
		logic [ID_W-1:0]        tag;
		logic                   ldst;
		logic [USP_EV_USED-1:0] ev;
		logic [USP_SRC_W-1:0]   src;
		logic [USP_VA_W-1:0]    va;
		logic [USP_PA_W-1:0]    pa;
		logic                   fault;
	} usp_prof_st_t;

	usp_prof_st_t            s_q;
	usp_prof_st_t            s_d;
	logic                    active;
	logic                    hit_zero;
	logic [USP_CNT_W-1:0]    reload;
	logic                    buf_in_valid;
	logic                    buf_in_ready;
	logic [REC_W-1:0]        buf_in_data;
	logic [REC_W-1:0]        buf_out_data;
	logic [USP_EV_USED-1:0]  ev_in;
	logic [USP_EV_W-1:0]     ev_rec;

	assign active   = prof_enable & ~el_top;
	assign hit_zero = (s_q.cnt <= USP_CNT_W'(1));
	assign reload   = (interval == '0) ? USP_CNT_W'(1) : interval;

	assign profiling_id_register = USP_MIN_INTERVAL;

	assign sample_tag     = active & disp_valid & hit_zero & (s_q.st == USP_IDLE);
	assign tag_active     = (s_q.st == USP_TRACK);
	assign tag_uop_id     = s_q.tag;
	assign xlat_req_valid = (s_q.st == USP_XLAT_REQ);
	assign xlat_va        = s_q.va;
	assign fault          = s_q.fault;
	assign buf_in_valid   = (s_q.st == USP_PUSH);

	always_comb begin
		ev_in = evt_bits;
		if (evt_bits[USP_EV_L1D_REF]) begin
			ev_in[USP_EV_L1D_ACC] = 1'b1;
		end
		if (evt_bits[USP_EV_LLC_MISS]) begin
			ev_in[USP_EV_LLC_ACC] = 1'b1;
		end
	end

	assign ev_rec      = {{(USP_EV_W-USP_EV_USED){1'b0}}, s_q.ev};
	assign buf_in_data = {s_q.pa, ev_rec, s_q.src, s_q.ldst};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (active && disp_valid) begin
			s_d.cnt = hit_zero ? reload : s_q.cnt - 1'b1;
		end
		if (!prof_enable) begin
			s_d.fault = 1'b0;
		end
		unique case (s_q.st)
			USP_IDLE: begin
				if (!prof_enable) begin
					s_d.va = base_va;
				end
				if (sample_tag) begin
					s_d.st   = USP_TRACK;
					s_d.tag  = disp_uop_id;
					s_d.ldst = disp_is_ldst;
					s_d.ev   = '0;
					s_d.src  = USP_SRC_L1D;
				end
			end
			USP_TRACK: begin
				if (evt_valid && evt_uop_id == s_q.tag) begin
					s_d.ev = s_q.ev | ev_in;
				end
				if (src_valid && src_uop_id == s_q.tag && s_q.ldst && usp_src_legal(src_code)) begin
					s_d.src = src_code;
				end
				if (done_valid && done_uop_id == s_q.tag) begin
					s_d.st = USP_XLAT_REQ;
					if (done_kind == USP_DONE_RETIRE) begin
						s_d.ev[USP_EV_RETIRED] = 1'b1;
					end
				end
			end
			USP_XLAT_REQ: begin
				if (xlat_req_ready) begin
					s_d.st = USP_XLAT_WAIT;
				end
			end
			USP_XLAT_WAIT: begin
				if (xlat_rsp_valid) begin
					if (xlat_fault) begin
						s_d.fault = 1'b1;
						s_d.st    = USP_IDLE;
					end else begin
						s_d.pa = xlat_pa;
						s_d.st = USP_PUSH;
					end
				end
			end
			USP_PUSH: begin
				if (buf_in_ready) begin
					s_d.va = s_q.va + USP_REC_BYTES;
					s_d.st = USP_IDLE;
				end
			end
			default: begin
				s_d.st = USP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q     <= '0;
			s_q.st  <= USP_IDLE;
			s_q.cnt <= USP_CNT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Record buffer
	// ----------------------------------------------------------------
	// A stalled memory path holds records here; while it is full the profiler stays in USP_PUSH and no new sample is tagged.
	usp_buf #(
		.W     (REC_W),
		.DEPTH (DEPTH)
	) u_buf (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in_data),
		.out_valid (mem_valid),
		.out_ready (mem_ready),
		.out_data  (buf_out_data)
	);

	assign mem_pa     = buf_out_data[REC_W-1 -: USP_PA_W];
	assign mem_events = buf_out_data[USP_EV_W+USP_SRC_W -: USP_EV_W];
	assign mem_source = buf_out_data[USP_SRC_W -: USP_SRC_W];
	assign mem_ldst   = buf_out_data[0];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_count_down;
		@(posedge clk) disable iff (!resetn)
		(active && disp_valid && !hit_zero) |=> (s_q.cnt == $past(s_q.cnt) - 1'b1);
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter did not step by one");

	property p_sample_cause;
		@(posedge clk) disable iff (!resetn)
		sample_tag |-> (disp_valid && active && hit_zero) ##1 (s_q.st == USP_TRACK);
	endproperty
	a_sample_cause: assert property (p_sample_cause) else $error("sample without zero count");

	property p_tag_id;
		@(posedge clk) disable iff (!resetn)
		sample_tag |=> (tag_uop_id == $past(disp_uop_id)) && tag_active;
	endproperty
	a_tag_id: assert property (p_tag_id) else $error("wrong micro-op tagged");

	property p_collect;
		@(posedge clk) disable iff (!resetn)
		(tag_active && evt_valid && evt_uop_id == s_q.tag) |=> ((s_q.ev & $past(evt_bits)) == $past(evt_bits));
	endproperty
	a_collect: assert property (p_collect) else $error("event bits not held");

	property p_write_after_done;
		@(posedge clk) disable iff (!resetn)
		(tag_active && !(done_valid && done_uop_id == s_q.tag)) |=> !xlat_req_valid;
	endproperty
	a_write_after_done: assert property (p_write_after_done) else $error("record before completion");

	property p_xlat_first;
		@(posedge clk) disable iff (!resetn)
		buf_in_valid |-> $past(s_q.st == USP_XLAT_WAIT) || $past(buf_in_valid);
	endproperty
	a_xlat_first: assert property (p_xlat_first) else $error("record pushed untranslated");

	property p_reserved_zero;
		@(posedge clk) disable iff (!resetn)
		mem_valid |-> (mem_events[31:13] == '0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved event bits set");

	property p_cache_pairs;
		@(posedge clk) disable iff (!resetn)
		mem_valid |-> (!mem_events[3] || mem_events[2]) && (!mem_events[9] || mem_events[8]);
	endproperty
	a_cache_pairs: assert property (p_cache_pairs) else $error("miss or refill without access");

	property p_source_legal;
		@(posedge clk) disable iff (!resetn)
		mem_valid |-> usp_src_legal(mem_source) && (mem_ldst || mem_source == USP_SRC_L1D);
	endproperty
	a_source_legal: assert property (p_source_legal) else $error("reserved data source");

	property p_frozen;
		@(posedge clk) disable iff (!resetn)
		!active |-> !sample_tag ##1 (s_q.cnt == $past(s_q.cnt));
	endproperty
	a_frozen: assert property (p_frozen) else $error("counter moved while disabled");

	property p_reload;
		@(posedge clk) disable iff (!resetn)
		(active && disp_valid && hit_zero) |=> (s_q.cnt == $past(reload));
	endproperty
	a_reload: assert property (p_reload) else $error("counter not reloaded");

	property p_min_interval;
		@(posedge clk) disable iff (!resetn)
		profiling_id_register == USP_MIN_INTERVAL;
	endproperty
	a_min_interval: assert property (p_min_interval) else $error("interval field wrong");

	property p_cov_record;
		@(posedge clk) disable iff (!resetn)
		mem_valid && mem_ready;
	endproperty
	c_cov_record: cover property (p_cov_record);

	property p_cov_fault;
		@(posedge clk) disable iff (!resetn)
		(s_q.st == USP_XLAT_WAIT) && xlat_rsp_valid && xlat_fault;
	endproperty
	c_cov_fault: cover property (p_cov_fault);

	property p_cov_stall;
		@(posedge clk) disable iff (!resetn)
		buf_in_valid && !buf_in_ready;
	endproperty
	c_cov_stall: cover property (p_cov_stall);

endmodule : usp_profiler

/* File: tb/usp_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Translation and record sink model
// ----------------------------------------------------------------
module usp_far_model import usp_pkg::*; (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                xlat_req_valid,
	input  wire logic [USP_VA_W-1:0] xlat_va,
	output logic                     xlat_req_ready,
	output logic                     xlat_rsp_valid,
	output logic [USP_PA_W-1:0]      xlat_pa,
	output logic                     xlat_fault,
	output logic                     mem_ready,
	input  wire logic                fail_next,
	input  wire logic                stall
);
	logic                busy;
	logic [2:0]          wait_n;
	logic [USP_VA_W-1:0] va_q;

	// The address bus toggles outside answers, so a stale value never reads as good.
	// translate then answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy           <= 1'b0;
			wait_n         <= 3'h0;
			va_q           <= '0;
			xlat_req_ready <= 1'b0;
			xlat_rsp_valid <= 1'b0;
			xlat_pa        <= '0;
			xlat_fault     <= 1'b0;
			mem_ready      <= 1'b0;
		end else begin
			xlat_rsp_valid <= 1'b0;
			xlat_fault     <= 1'b0;
			xlat_pa        <= ~xlat_pa;
			mem_ready      <= !stall && ($urandom_range(1, 0) == 1);
			if (busy) begin
				if (wait_n == 3'h0) begin
					busy           <= 1'b0;
					xlat_rsp_valid <= 1'b1;
					xlat_fault     <= fail_next;
					xlat_pa        <= fail_next ? ~xlat_pa : va_q[USP_PA_W-1:0] + 44'h00000001000;
				end else begin
					wait_n <= wait_n - 3'h1;
				end
			end else if (xlat_req_valid && xlat_req_ready) begin
				busy           <= 1'b1;
				va_q           <= xlat_va;
				wait_n         <= 3'($urandom_range(4, 0));
				xlat_req_ready <= 1'b0;
			end else begin
				xlat_req_ready <= ($urandom_range(1, 0) == 1);
			end
		end
	end

endmodule : usp_far_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench import usp_pkg::*;;
	typedef struct packed {
		logic [43:0] pa;
		logic [31:0] ev;
		logic [7:0]  src;
		logic        ldst;
	} usp_rec_t;
	logic clk = 0, resetn = 0, prof_enable = 0, el_top = 0, disp_valid = 0, disp_is_ldst = 0;
	logic evt_valid = 0, src_valid = 0, done_valid = 0, fail_next = 0, stall = 0;
	logic [23:0] interval = 24'h000400;
	logic [47:0] base_va = 48'h000012340000;
	logic [7:0] disp_uop_id = 0, evt_uop_id = 0, src_uop_id = 0, done_uop_id = 0, src_code = 0;
	logic [12:0] evt_bits = 0;
	logic [1:0] done_kind = 0;
	logic [23:0] profiling_id_register;
	logic sample_tag, tag_active, xlat_req_valid, xlat_req_ready, xlat_rsp_valid, xlat_fault;
	logic fault, mem_valid, mem_ready, mem_ldst;
	logic [7:0] tag_uop_id, mem_source;
	logic [47:0] xlat_va;
	logic [43:0] xlat_pa, mem_pa;
	logic [31:0] mem_events;
	int failures = 0, checks_done = 0, rec_n = 0, n_next = 1024, src_i = 0;
	usp_rec_t exp_q[$];
	logic [7:0] srcs[8] = '{USP_SRC_L1D, USP_SRC_L2, USP_SRC_PEER_CPU, USP_SRC_LOCAL_CL,
		USP_SRC_SYS_CACHE, USP_SRC_PEER_CL, USP_SRC_REMOTE, USP_SRC_DRAM};

	always #25 clk = ~clk;

	usp_profiler dut (.clk, .resetn, .prof_enable, .el_top, .interval, .base_va,
		.profiling_id_register, .disp_valid, .disp_uop_id, .disp_is_ldst, .sample_tag,
		.tag_active, .tag_uop_id, .evt_valid, .evt_uop_id, .evt_bits, .src_valid,
		.src_uop_id, .src_code, .done_valid, .done_uop_id, .done_kind, .xlat_req_valid,
		.xlat_req_ready, .xlat_va, .xlat_rsp_valid, .xlat_pa, .xlat_fault, .fault,
		.mem_valid, .mem_ready, .mem_pa, .mem_events, .mem_source, .mem_ldst);
	usp_far_model far (.clk, .resetn, .xlat_req_valid, .xlat_va, .xlat_req_ready,
		.xlat_rsp_valid, .xlat_pa, .xlat_fault, .mem_ready, .fail_next, .stall);

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
		checks_done++;
		if (e !== s) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	// Dispatches while inactive must neither sample nor move the counter.
	task automatic idle_disp();
		for (int i = 0; i < 60; i++) begin
			disp_valid = 1;
			@(negedge clk);
			chk("sample_tag", 0, sample_tag);
			step();
		end
		disp_valid = 0;
	endtask : idle_disp

	task automatic run_sample(input logic [1:0] kind, input logic ldst, input logic flt);
		logic [7:0]  sid;
		logic [12:0] ev;
		usp_rec_t    r;
		int          cnt;
		cnt = n_next;
		interval = 24'h000400 + 24'($urandom_range(16, 0));
		n_next = int'(interval);
		fail_next = flt;
		disp_is_ldst = ldst;
		for (int i = 0; i < cnt; i++) begin
			disp_valid = 1;
			disp_uop_id = 8'($urandom);
			sid = disp_uop_id;
			@(negedge clk);
			chk("sample_tag", (i == cnt - 1), sample_tag);
			step();
		end
		disp_valid = 0;
		chk("tag_uop_id", {1'b1, sid}, {tag_active, tag_uop_id});
		// A report for another micro-op with every flag set must not leak in.
		{evt_valid, evt_uop_id, evt_bits} = {1'b1, ~sid, 13'h1fff};
		step();
		ev = 13'($urandom) & 13'h1ffd;
		{evt_uop_id, evt_bits, src_valid, src_uop_id, src_code} = {sid, ev, 1'b1, sid, srcs[src_i]};
		{done_valid, done_uop_id, done_kind} = {1'b1, sid, kind};
		r.ev = {19'h0, ev};
		r.ev[2] = ev[2] | ev[3];
		r.ev[8] = ev[8] | ev[9];
		r.ev[1] = (kind == USP_DONE_RETIRE);
		r.src = ldst ? srcs[src_i] : 8'h00;
		r.ldst = ldst;
		r.pa = 44'(base_va + 48'(rec_n) * USP_REC_BYTES) + 44'h00000001000;
		if (!flt) begin
			exp_q.push_back(r);
			rec_n++;
		end
		src_i = (src_i + 3) % 8;
		step();
		{evt_valid, src_valid, done_valid} = 3'b000;
		chk("tag_active", 0, tag_active);
		repeat (20) step();
	endtask : run_sample

	always @(posedge clk) begin
		if (resetn === 1'b1 && mem_valid === 1'b1 && mem_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("mem_valid", 0, 1);
			end else begin
				usp_rec_t e;
				e = exp_q.pop_front();
				chk("record", e, {mem_pa, mem_events, mem_source, mem_ldst});
			end
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h8f2961ad));
		repeat (12) @(posedge clk);
		#1;
		resetn = 1;
		chk("profiling_id_register", 24'h000400, profiling_id_register);
		chk("mem_valid", 0, mem_valid);
		// The record pointer only loads its base while profiling is off, so keep it off one edge.
		step();
		prof_enable = 1;
		run_sample(USP_DONE_RETIRE, 1, 0);
		el_top = 1;
		idle_disp();
		el_top = 0;
		stall = 1;
		run_sample(USP_DONE_ABORT, 0, 0);
		run_sample(USP_DONE_FLUSH, 1, 0);
		chk("mem_valid", 1, mem_valid);
		stall = 0;
		run_sample(USP_DONE_RETIRE, 1, 1);
		for (int i = 0; i < 200 && fault !== 1'b1; i++)
			step();
		chk("fault", 1, fault);
		base_va = 48'h0000abc00000;
		prof_enable = 0;
		idle_disp();
		chk("fault", 0, fault);
		rec_n = 0;
		prof_enable = 1;
		run_sample(USP_DONE_RETIRE, 1, 0);
		for (int i = 0; i < 200 && exp_q.size() > 0; i++)
			step();
		chk("pending", 0, exp_q.size());
		report_and_stop();
	end

endmodule : testbench
